// ==== core/sample_pack_pkg.sv ====
package sample_pack_pkg;
    localparam int SAMPLE_W = 6;
    localparam int SLOTS = 4;
    localparam int SLOT_W = 2;
    localparam int COLLECT_W = 24;
    localparam int REC_LEN = 4096;
    localparam int CONV_W = 12;
    localparam int LOW_DIGITS = 6;
    localparam int LOW_W = 24;
    localparam int HIGH_W = 30;
    localparam int TIME_W = 54;
    localparam int TWORD_W = 12;
    localparam int TWORDS = 5;
    localparam int TSEL_W = 3;
    localparam int TIME_PAD_W = 60;
    localparam int PLAY_ZERO_W = 12;
    localparam logic [SLOT_W-1:0] LAST_SLOT = 2'h3;
    localparam logic [TSEL_W-1:0] LAST_TSEL = 3'h4;
    localparam logic [CONV_W-1:0] LAST_CONV = 12'hfff;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [9:0] HEADER_MARK = 10'h2a5;
    typedef enum logic [1:0] {
        DR_IDLE = 2'b00,
        DR_HEAD = 2'b01,
        DR_TIME = 2'b11,
        DR_DATA = 2'b10
    } drain_state_t;
endpackage

// ==== core/host_link_if.sv ====
`timescale 1ns/100ps
interface host_link_if;
    import sample_pack_pkg::*;
    // Acquisition control
    logic start_cmd;
    logic stop_cmd;
    // Sample channel
    logic data_ready;
    logic data_req;
    logic data_ack;
    logic [SAMPLE_W-1:0] data_word;
    // Time channel
    logic time_ready;
    logic time_req;
    logic [TSEL_W-1:0] time_sel;
    logic time_ack;
    logic [TWORD_W-1:0] time_word;

    modport device (
        input start_cmd, stop_cmd, data_req, time_req, time_sel,
        output data_ready, data_ack, data_word,
        output time_ready, time_ack, time_word
    );
    modport host (
        output start_cmd, stop_cmd, data_req, time_req, time_sel,
        input data_ready, data_ack, data_word,
        input time_ready, time_ack, time_word
    );
endinterface

// ==== core/bcd_time_counter.sv ====
`timescale 1ns/100ps
module bcd_time_counter import sample_pack_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Count enable, one cycle per microsecond
    input wire logic tick,
    // Tenths of a second down to microseconds
    output logic [LOW_W-1:0] value
);
    logic [LOW_W-1:0] next_value;

    always_comb begin
        logic carry;
        carry = tick;
        next_value = value;
        for (int d = 0; d < LOW_DIGITS; d++) begin
            if (carry) begin
                if (value[d*4 +: 4] == BCD_MAX) begin
                    next_value[d*4 +: 4] = 4'h0;
                end else begin
                    next_value[d*4 +: 4] = value[d*4 +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
    end

    // Wraps at a second boundary; seconds come from the timing source
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            value <= '0;
        end else begin
            value <= next_value;
        end
    end
endmodule

// ==== core/sample_pack_time_tag.sv ====
`timescale 1ns/100ps
module sample_pack_time_tag import sample_pack_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Converter pins
    input wire logic tone_in,
    input wire logic eoc_in,
    input wire logic [SAMPLE_W-1:0] adc_sample,
    output logic adc_convert,
    // Timing pins
    input wire logic tick_in,
    input wire logic [HIGH_W-1:0] station_timing_source,
    input wire logic playback_mode,
    // Status
    output logic running,
    output logic overrun,
    // Host side
    host_link_if.device link
);
    // Two-stage synchronisers for every pin
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_prev;
    logic [SAMPLE_W-1:0] sample_a;
    logic [SAMPLE_W-1:0] sample_b;
    logic [HIGH_W-1:0] high_a;
    logic [HIGH_W-1:0] high_b;
    logic playback_a;
    logic playback_b;
    logic tone_rise;
    logic tick_rise;
    logic eoc_rise;
    logic take_sample;

    logic [SLOT_W-1:0] slot;
    logic [SLOT_W-1:0] rd_slot;
    logic word_full;
    logic [COLLECT_W-1:0] collect;
    logic [CONV_W-1:0] conv_count;
    logic time_strobe;
    logic time_held;
    logic [TIME_W-1:0] time_reg;
    logic [LOW_W-1:0] low_time;
    logic [LOW_W-1:0] low_tagged;
    logic last_time_read;
    logic last_data_read;

    function automatic logic [SAMPLE_W-1:0] pick_sample(
        input logic [COLLECT_W-1:0] w,
        input logic [SLOT_W-1:0] i
    );
        pick_sample = w[i*SAMPLE_W +: SAMPLE_W];
    endfunction

    // Word 0 carries the day digits, the last one the microseconds
    function automatic logic [TWORD_W-1:0] pick_time(
        input logic [TIME_W-1:0] t,
        input logic [TSEL_W-1:0] i
    );
        logic [TIME_PAD_W-1:0] padded;
        padded = {{(TIME_PAD_W-TIME_W){1'b0}}, t};
        pick_time = padded[(TWORDS-1-i)*TWORD_W +: TWORD_W];
    endfunction

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_prev <= '0;
            sample_a <= '0;
            sample_b <= '0;
            high_a <= '0;
            high_b <= '0;
            playback_a <= 1'b0;
            playback_b <= 1'b0;
        end else begin
            sync_a <= {eoc_in, tick_in, tone_in};
            sync_b <= sync_a;
            sync_prev <= sync_b;
            sample_a <= adc_sample;
            sample_b <= sample_a;
            high_a <= station_timing_source;
            high_b <= high_a;
            playback_a <= playback_mode;
            playback_b <= playback_a;
        end
    end

    assign tone_rise = sync_b[0] & ~sync_prev[0];
    assign tick_rise = sync_b[1] & ~sync_prev[1];
    assign eoc_rise = sync_b[2] & ~sync_prev[2];
    // Pulses ignored while stopped or word unread
    assign take_sample = eoc_rise & running & ~word_full;
    assign last_data_read = link.data_req & word_full &
        (rd_slot == LAST_SLOT);
    assign last_time_read = link.time_req & time_held &
        (link.time_sel == LAST_TSEL);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            adc_convert <= 1'b0;
        end else begin
            adc_convert <= tone_rise & running;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            running <= 1'b0;
        end else if (link.stop_cmd) begin
            running <= 1'b0;
        end else if (link.start_cmd) begin
            running <= 1'b1;
        end
    end

    // Sticky until the next start so lost samples stay visible
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            overrun <= 1'b0;
        end else if (eoc_rise & running & word_full) begin
            overrun <= 1'b1;
        end else if (link.start_cmd) begin
            overrun <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            slot <= '0;
            collect <= '0;
        end else if (!running) begin
            slot <= '0;
        end else if (take_sample) begin
            collect[slot*SAMPLE_W +: SAMPLE_W] <= sample_b;
            slot <= slot + 2'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            word_full <= 1'b0;
        end else if (!running) begin
            word_full <= 1'b0;
        end else if (take_sample && slot == LAST_SLOT) begin
            word_full <= 1'b1;
        end else if (last_data_read) begin
            word_full <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conv_count <= '0;
            time_strobe <= 1'b0;
        end else if (!running) begin
            conv_count <= '0;
            time_strobe <= 1'b0;
        end else begin
            time_strobe <= take_sample && conv_count == '0;
            if (take_sample) begin
                conv_count <= conv_count + 12'h1;
            end
        end
    end

    bcd_time_counter u_low_time (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick_rise),
        .value(low_time)
    );

    assign low_tagged = playback_b ?
        {low_time[LOW_W-1:PLAY_ZERO_W], {PLAY_ZERO_W{1'b0}}} : low_time;

    // Load on strobe, hold until read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            time_reg <= '0;
            time_held <= 1'b0;
        end else if (time_strobe && (!time_held || last_time_read)) begin
            // High part from the timing source
            time_reg <= {high_b, low_tagged};
            time_held <= 1'b1;
        end else if (last_time_read) begin
            time_held <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_slot <= '0;
            link.data_ack <= 1'b0;
            link.data_word <= '0;
        end else begin
            link.data_ack <= link.data_req & word_full;
            if (!running) begin
                rd_slot <= '0;
            end else if (link.data_req && word_full) begin
                link.data_word <= pick_sample(collect, rd_slot);
                rd_slot <= rd_slot + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            link.time_ack <= 1'b0;
            link.time_word <= '0;
        end else begin
            link.time_ack <= link.time_req & time_held;
            if (link.time_req && time_held) begin
                link.time_word <= pick_time(time_reg, link.time_sel);
            end
        end
    end

    assign link.data_ready = word_full;
    assign link.time_ready = time_held;
endmodule

// ==== core/record_host.sv ====
`timescale 1ns/100ps
module record_host import sample_pack_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Operator control
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic tape_full,
    // Tape output stream
    output logic rec_valid,
    output logic [TWORD_W-1:0] rec_word,
    output drain_state_t rec_kind,
    output logic rec_unit,
    // Device side
    host_link_if.host link
);
    logic [SAMPLE_W-1:0] mem [0:2*REC_LEN-1];
    logic [TWORD_W-1:0] tag [0:2*TWORDS-1];
    logic data_pend;
    logic time_pend;
    logic fill_half;
    logic [CONV_W-1:0] fill_idx;
    logic [1:0] half_full;
    logic drain_half;
    logic [CONV_W-1:0] drain_idx;
    logic [TSEL_W-1:0] drain_tsel;
    logic tape_prev;
    logic swap_due;
    drain_state_t state;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            link.start_cmd <= 1'b0;
            link.stop_cmd <= 1'b0;
        end else begin
            link.start_cmd <= start_req;
            link.stop_cmd <= stop_req;
        end
    end

    // Time is pulled first so a record's tag lands before its data
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            time_pend <= 1'b0;
            link.time_req <= 1'b0;
            link.time_sel <= '0;
        end else begin
            link.time_req <= link.time_ready & ~time_pend & ~link.time_req;
            if (link.time_ready && !time_pend && !link.time_req) begin
                time_pend <= 1'b1;
            end else if (link.time_ack) begin
                time_pend <= 1'b0;
                if (link.time_sel == LAST_TSEL) begin
                    link.time_sel <= '0;
                end else begin
                    link.time_sel <= link.time_sel + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (link.time_ack) begin
            tag[fill_half*TWORDS + link.time_sel] <= link.time_word;
        end
        if (link.data_ack) begin
            mem[{fill_half, fill_idx}] <= link.data_word;
        end
    end

    // Fill one half, then the other
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data_pend <= 1'b0;
            link.data_req <= 1'b0;
            fill_half <= 1'b0;
            fill_idx <= '0;
        end else begin
            link.data_req <= link.data_ready & ~data_pend &
                ~link.data_req & ~time_pend & ~link.time_ready;
            if (link.data_req) begin
                data_pend <= 1'b1;
            end else if (link.data_ack) begin
                data_pend <= 1'b0;
            end
            if (link.data_ack) begin
                fill_idx <= fill_idx + 12'h1;
                if (fill_idx == LAST_CONV) begin
                    fill_half <= ~fill_half;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tape_prev <= 1'b0;
            swap_due <= 1'b0;
            rec_unit <= 1'b0;
        end else begin
            tape_prev <= tape_full;
            if (state == DR_IDLE && half_full[drain_half]) begin
                rec_unit <= rec_unit ^ swap_due;
                swap_due <= tape_full & ~tape_prev;
            end else if (tape_full && !tape_prev) begin
                swap_due <= 1'b1;
            end
        end
    end

    // One word per cycle, far above the sample rate
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= DR_IDLE;
            half_full <= '0;
            drain_half <= 1'b0;
            drain_idx <= '0;
            drain_tsel <= '0;
            rec_valid <= 1'b0;
            rec_word <= '0;
            rec_kind <= DR_IDLE;
        end else begin
            rec_valid <= state != DR_IDLE;
            rec_kind <= state;
            if (link.data_ack && fill_idx == LAST_CONV) begin
                half_full[fill_half] <= 1'b1;
            end
            unique case (state)
                DR_IDLE: begin
                    if (half_full[drain_half]) begin
                        state <= DR_HEAD;
                    end
                end
                DR_HEAD: begin
                    rec_word <= {HEADER_MARK, drain_half, rec_unit};
                    drain_tsel <= '0;
                    state <= DR_TIME;
                end
                DR_TIME: begin
                    rec_word <= tag[drain_half*TWORDS + drain_tsel];
                    drain_tsel <= drain_tsel + 3'h1;
                    if (drain_tsel == LAST_TSEL) begin
                        drain_idx <= '0;
                        state <= DR_DATA;
                    end
                end
                DR_DATA: begin
                    rec_word <= {{(TWORD_W-SAMPLE_W){1'b0}},
                        mem[{drain_half, drain_idx}]};
                    drain_idx <= drain_idx + 12'h1;
                    if (drain_idx == LAST_CONV) begin
                        half_full[drain_half] <= 1'b0;
                        drain_half <= ~drain_half;
                        state <= DR_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ==== tb/link_rules_sva.sv ====
`timescale 1ns/100ps
module link_rules_sva import sample_pack_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Acquisition control
    input wire logic start_cmd,
    input wire logic stop_cmd,
    // Sample channel
    input wire logic data_ready,
    input wire logic data_req,
    input wire logic data_ack,
    input wire logic [SAMPLE_W-1:0] data_word,
    // Time channel
    input wire logic time_ready,
    input wire logic time_req,
    input wire logic [TSEL_W-1:0] time_sel,
    input wire logic time_ack,
    input wire logic [TWORD_W-1:0] time_word
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [SLOT_W-1:0] rd_slot;
    wire logic data_take = data_req && data_ready;
    wire logic time_take = time_req && time_ready;
    // Mirrors the read slot so the fourth read can be told apart
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_slot <= '0;
        end else if (stop_cmd) begin
            rd_slot <= '0;
        end else if (data_take) begin
            rd_slot <= rd_slot + 2'h1;
        end
    end
    data_answer_a:
        assert property (data_take |=> data_ack)
        else $error("sample read not acknowledged");
    data_refuse_a:
        assert property (!data_take |=> !data_ack)
        else $error("sample ack without a taken read");
    data_hold_a:
        assert property (!data_take |=> $stable(data_word))
        else $error("sample word changed without a read");
    word_done_a:
        assert property (data_take && rd_slot == LAST_SLOT |=> !data_ready)
        else $error("ready stayed up after fourth read");
    word_keep_a:
        assert property (data_take && rd_slot != LAST_SLOT && !stop_cmd
            && !$past(stop_cmd) |=> data_ready)
        else $error("ready dropped before fourth read");
    time_answer_a:
        assert property (time_take |=> time_ack)
        else $error("time read not acknowledged");
    time_refuse_a:
        assert property (!time_take |=> !time_ack)
        else $error("time ack without a taken read");
    time_word_a:
        assert property (!time_take |=> $stable(time_word))
        else $error("time word changed without a read");
    time_hold_a:
        assert property (time_ready && !(time_take && time_sel == LAST_TSEL)
            |=> time_ready)
        else $error("time released before last word read");
    stop_quiet_a:
        assert property (stop_cmd |=> ##1 !data_ready [*8])
        else $error("word ready while stopped");
    cover property (data_take && rd_slot == LAST_SLOT);
    cover property (time_take && time_sel == LAST_TSEL);
    cover property (start_cmd);
    cover property (stop_cmd);
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top import sample_pack_pkg::*; ;
    localparam logic [HIGH_W-1:0] HIGH_T = 30'h2b3c4d5e;
    localparam int TAPE_LEN = REC_LEN + TWORDS + 1;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic tone_in = 1'b0;
    logic eoc_in = 1'b0;
    logic [SAMPLE_W-1:0] adc_sample = '0;
    logic tick_in = 1'b0;
    logic start_req = 1'b0;
    logic stop_req = 1'b0;
    logic tape_full = 1'b0;
    logic playback_mode = 1'b0;
    logic adc_convert, running, overrun, rec_valid, rec_unit;
    logic [TWORD_W-1:0] rec_word;
    drain_state_t rec_kind;
    int failures = 0;
    int n_tests = 0;
    int n_rec = 0;
    int n_conv = 0;

    host_link_if link();

    always #25 core_clk = ~core_clk;

    sample_pack_time_tag i_sample_pack_time_tag (
        .core_clk(core_clk), .rst(rst), .tone_in(tone_in),
        .eoc_in(eoc_in), .adc_sample(adc_sample),
        .adc_convert(adc_convert), .tick_in(tick_in),
        .station_timing_source(HIGH_T), .playback_mode(playback_mode),
        .running(running), .overrun(overrun), .link(link.device)
    );
    record_host i_record_host (
        .core_clk(core_clk), .rst(rst), .start_req(start_req),
        .stop_req(stop_req), .tape_full(tape_full),
        .rec_valid(rec_valid), .rec_word(rec_word),
        .rec_kind(rec_kind), .rec_unit(rec_unit), .link(link.host)
    );
    link_rules_sva i_link_rules_sva (
        .core_clk(core_clk), .rst(rst), .start_cmd(link.start_cmd),
        .stop_cmd(link.stop_cmd), .data_ready(link.data_ready),
        .data_req(link.data_req), .data_ack(link.data_ack),
        .data_word(link.data_word), .time_ready(link.time_ready),
        .time_req(link.time_req), .time_sel(link.time_sel),
        .time_ack(link.time_ack), .time_word(link.time_word)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic give_up;
        failures++;
        tally_and_finish();
    endtask

    // Inputs move 2 ns after the rising edge, clear of sampling
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #2;
    endtask

    task automatic tick_pulse;
        tick_in = 1'b1;
        step(10);
        tick_in = 1'b0;
        step(10);
    endtask

    function automatic logic [SAMPLE_W-1:0] smp(input int n);
        return 6'(n) ^ 6'(n >> 6);
    endfunction

    // Record 0 tagged at 12 us, record 1 after 99 more ticks
    function automatic logic [TWORD_W-1:0] tape_exp(input int n);
        logic [TIME_PAD_W-1:0] t;
        int r;
        int k;
        r = n / TAPE_LEN;
        k = n % TAPE_LEN;
        t = {6'h0, HIGH_T, (r == 0) ? 24'h000012 : 24'h000111};
        if (k == 0) return {HEADER_MARK, 1'(r), 1'(r)};
        if (k <= TWORDS) return t[71 - 12 * k -: 12];
        return {6'h0, smp(r * REC_LEN + k - TWORDS - 1)};
    endfunction

    function automatic drain_state_t kind_exp(input int n);
        if (n % TAPE_LEN == 0) return DR_HEAD;
        return (n % TAPE_LEN <= TWORDS) ? DR_TIME : DR_DATA;
    endfunction

    // Tone rise, wait for the convert pulse, then end of conversion
    task automatic conv(input logic [SAMPLE_W-1:0] v);
        int i;
        adc_sample = v;
        tone_in = 1'b1;
        for (i = 0; i < 8 && adc_convert !== 1'b1; i++) begin
            step(1);
        end
        if (i == 8) give_up();
        step(1);
        eoc_in = 1'b1;
        tone_in = 1'b0;
        step(2);
        eoc_in = 1'b0;
        step(1);
    endtask

    task automatic wait_ready(input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && link.data_ready !== lvl; i++) begin
            step(1);
        end
        if (i == lim) give_up();
    endtask

    always @(posedge core_clk) begin
        if (rec_valid === 1'b1) begin
            check(16'(rec_word), 16'(tape_exp(n_rec)));
            check(16'(rec_kind), 16'(kind_exp(n_rec)));
            check(16'(rec_unit), 16'(n_rec / TAPE_LEN));
            n_rec <= n_rec + 1;
        end
        if (adc_convert === 1'b1) begin
            n_conv <= n_conv + 1;
        end
    end

    initial begin
        step(3);
        rst = 1'b0;
        repeat (12) tick_pulse();
        start_req = 1'b1;
        step(1);
        start_req = 1'b0;
        step(4);
        check(16'(running), 16'h0001);
        // Host must empty each word before the next sample lands
        for (int n = 0; n < 2 * REC_LEN; n++) begin
            if (n == 1) repeat (99) tick_pulse();
            if (n == 6000) tape_full = 1'b1;
            conv(smp(n));
            if (n % SLOTS == SLOTS - 1) begin
                wait_ready(1'b1, 10);
                wait_ready(1'b0, 60);
            end
        end
        for (int i = 0; i < 6000 && n_rec < 2 * TAPE_LEN; i++) begin
            step(1);
        end
        check(16'(n_rec), 16'(2 * TAPE_LEN));
        check(16'(n_conv), 16'(2 * REC_LEN));
        check(16'(overrun), 16'h0000);
        $display("record test done");
        stop_req = 1'b1;
        step(1);
        stop_req = 1'b0;
        step(4);
        check(16'(running), 16'h0000);
        for (int n = 0; n < SLOTS; n++) begin
            tone_in = 1'b1;
            eoc_in = 1'b1;
            step(4);
            tone_in = 1'b0;
            eoc_in = 1'b0;
            step(4);
        end
        check(16'(n_conv), 16'(2 * REC_LEN));
        check(16'(link.data_ready), 16'h0000);
        $display("stop test done");
        // Restart in playback; the new record tag drops sub-ms digits
        playback_mode = 1'b1;
        start_req = 1'b1;
        step(1);
        start_req = 1'b0;
        step(4);
        conv(6'h15);
        step(2);
        check(16'(link.time_ready), 16'h0001);
        for (int i = 0; i < 40 && link.time_ready !== 1'b0; i++) begin
            step(1);
        end
        check(16'(link.time_ready), 16'h0000);
        check(16'(link.time_word), 16'h0000);
        $display("playback test done");
        tally_and_finish();
    end
endmodule
